// ==== bench/test_ts_descrambler.sv ====
// Self-checking bench for the descrambler, one task per scenario.
// Assumes the source model on the input side; bench consumes output.
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin \
  error_cnt++; $display("wrong value %s expected %0h seen %0h", nm, ex, sn); \
  end end
module test_ts_descrambler;
  localparam logic [63:0] KA = 64'h0123456789ABCDEF;  // First key
  localparam logic [63:0] KB = 64'hFEDCBA9876543210;  // Second key
  logic                   clk_sys = 1'b0;
  logic                   nrst = 1'b0;
  logic [255:0]           sys_key = {4{64'h0F1E2D3C4B5A6978}};
  logic                   key_wr, in_valid, in_ready, out_valid;
  logic                   hold = 1'b0;  // Consumer stall
  logic [0:0]             key_sid;
  logic [63:0]            key_even, key_odd;
  ts_descr_pkg::ts_beat_s in_beat, out_beat;
  ts_descr_pkg::ts_beat_s outq [$];  // Accepted output beats
  logic [7:0]             pin [188];  // Packet being offered
  logic [7:0]             a [188], b [188], c [188], d [188];
  int                     error_cnt = 0;
  int                     check_count = 0;

  always #2 clk_sys = ~clk_sys;  // 250 MHz

  ts_descrambler dut (.clk_sys(clk_sys), .nrst(nrst), .sys_key(sys_key),
    .key_wr(key_wr), .key_sid(key_sid), .key_even(key_even),
    .key_odd(key_odd), .in_valid(in_valid), .in_ready(in_ready),
    .in_beat(in_beat), .out_valid(out_valid), .out_ready(~hold),
    .out_beat(out_beat));
  ts_source_model src (.clk_sys(clk_sys), .in_ready(in_ready),
    .in_valid(in_valid), .in_beat(in_beat), .key_wr(key_wr),
    .key_sid(key_sid), .key_even(key_even), .key_odd(key_odd));

  // Collect every beat the consumer accepts
  always @(posedge clk_sys) begin
    if (nrst && out_valid && !hold) outq.push_back(out_beat);
  end

  // Header fields from package layout, payload a simple ramp
  function automatic void build(input logic [1:0] tsc, input logic [1:0] afc,
                                input logic [7:0] seed);
    pin[0] = 8'h47;
    pin[1] = 8'h01;
    pin[2] = 8'h00;
    pin[3] = {tsc, afc, 4'h0};
    for (int i = 4; i < 188; i++) pin[i] = seed + 8'(i) * 8'h1D;
    if (afc == ts_descr_pkg::AFC_BOTH) pin[4] = 8'h01;  // One adaptation byte
  endfunction : build

  // Count of differing bytes in a range; unknowns count as different
  function automatic logic [7:0] diffs(input logic [7:0] x [188],
      input logic [7:0] y [188], input int lo, input int hi);
    logic [7:0] n = 8'h00;
    for (int i = lo; i <= hi; i++) if (x[i] !== y[i]) n++;
    return n;
  endfunction : diffs

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Send pin on a stream and gather one whole packet back
  task automatic xfer(input logic [0:0] sid, output logic [7:0] r [188]);
    int n = 0;
    ts_descr_pkg::ts_beat_s bt;
    src.send_pkt(sid, pin);
    while (outq.size() < 188 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    `CHK("beats", 1'b1, outq.size() == 188)
    if (outq.size() < 188) stop_test();
    for (int i = 0; i < 188; i++) begin
      bt = outq.pop_front();
      r[i] = bt.data;
      `CHK("sop", (i == 0), bt.sop)
      `CHK("sid", sid, bt.sid)
    end
  endtask : xfer

  // Clear and reserved codes pass whole packets untouched although keys are live
  task automatic t_clear();
    for (int t = 0; t < 2; t++) begin
      build(2'(t), ts_descr_pkg::AFC_PAY, 8'h10);
      xfer(1'b0, a);
      `CHK("clear", 8'h00, diffs(a, pin, 0, 187))
    end
    $display("test clear done");
  endtask : t_clear

  // Keyless stream stays clear; keyed stream scrambles payload only
  task automatic t_scramble();
    build(ts_descr_pkg::TSC_EVEN, ts_descr_pkg::AFC_PAY, 8'h30);
    xfer(1'b1, b);
    `CHK("no key", 8'h00, diffs(b, pin, 0, 187))
    xfer(1'b0, a);
    `CHK("header", 8'h00, diffs(a, pin, 0, 3))
    `CHK("payload", 1'b1, diffs(a, pin, 4, 187) > 150)
    xfer(1'b0, b);
    `CHK("restart", 8'h00, diffs(a, b, 0, 187))
    $display("test scramble done");
  endtask : t_scramble

  // Odd code uses odd key; swapped pair gives same result on even
  task automatic t_keys();
    build(ts_descr_pkg::TSC_ODD, ts_descr_pkg::AFC_PAY, 8'h30);
    xfer(1'b0, b);
    src.load_keys(1'b0, KB, KA);
    build(ts_descr_pkg::TSC_EVEN, ts_descr_pkg::AFC_PAY, 8'h30);
    xfer(1'b0, c);
    `CHK("odd", 8'h00, diffs(b, c, 4, 187))
    `CHK("even", 1'b1, diffs(a, c, 4, 187) > 150)
    // Key write mid-packet must wait for the next packet start
    fork
      xfer(1'b0, d);
      begin
        repeat (100) @(posedge clk_sys);
        #1;
        src.load_keys(1'b0, KA, KB);
      end
    join
    `CHK("mid key", 8'h00, diffs(c, d, 0, 187))
    xfer(1'b0, d);
    `CHK("next key", 8'h00, diffs(a, d, 0, 187))
    $display("test keys done");
  endtask : t_keys

  // Adaptation bytes pass; six tail bytes are keystream combined
  task automatic t_tail();
    build(ts_descr_pkg::TSC_EVEN, ts_descr_pkg::AFC_BOTH, 8'h40);
    xfer(1'b0, b);
    `CHK("adapt", 8'h00, diffs(b, pin, 0, 5))
    `CHK("tail mixed", 1'b1, diffs(b, pin, 182, 187) != 0)
    pin[187] = pin[187] ^ 8'h5A;
    xfer(1'b0, c);
    `CHK("blocks", 8'h00, diffs(b, c, 0, 186))
    `CHK("tail", 8'h5A, b[187] ^ c[187])
    $display("test tail done");
  endtask : t_tail

  // System key enters the cipher; second bank matches first
  task automatic t_banks();
    sys_key = ~sys_key;
    build(ts_descr_pkg::TSC_EVEN, ts_descr_pkg::AFC_PAY, 8'h30);
    xfer(1'b0, b);
    `CHK("sys key", 1'b1, diffs(a, b, 4, 187) > 150)
    sys_key = ~sys_key;
    src.load_keys(1'b1, KA, KB);
    xfer(1'b1, b);
    `CHK("bank", 8'h00, diffs(a, b, 0, 187))
    $display("test banks done");
  endtask : t_banks

  // Stalled consumer fills the buffer until input is refused
  task automatic t_full();
    build(2'h0, ts_descr_pkg::AFC_PAY, 8'h50);
    hold = 1'b1;
    fork
      xfer(1'b0, b);
      begin
        repeat (50) @(posedge clk_sys);
        #1;
        `CHK("full", 2'b10, {out_valid, in_ready})
        hold = 1'b0;
      end
    join
    `CHK("drained", 1'b0, out_valid)
    `CHK("clear", 8'h00, diffs(b, pin, 0, 187))
    $display("test full done");
  endtask : t_full

  // Hang guard well above the cycle budget
  initial begin
    #400000;
    error_cnt++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    src.load_keys(1'b0, KA, KB);
    t_clear();
    t_scramble();
    t_keys();
    t_tail();
    t_banks();
    t_full();
    `CHK("offers", 0, src.hangs)
    stop_test();
  end
endmodule : test_ts_descrambler

// ==== bench/ts_source_model.sv ====
// Far-side model: demultiplexer offering packet bytes, ECM logic loading keys.
// Assumes the descrambler's valid/ready byte port and one shared clock.
`timescale 1ns/1ns
module ts_source_model (
  input  wire logic              clk_sys,
  input  wire logic              in_ready,
  output logic                   in_valid,
  output ts_descr_pkg::ts_beat_s in_beat,
  output logic                   key_wr,
  output logic [0:0]             key_sid,
  output logic [63:0]            key_even,
  output logic [63:0]            key_odd
);
  int hangs = 0;  // Offers never taken within bound

  // Idle values from time zero
  initial begin
    in_valid = 1'b0;
    in_beat  = '0;
    key_wr   = 1'b0;
    key_sid  = 1'b0;
    key_even = 64'h0;
    key_odd  = 64'h0;
  end

  // Whole packet, byte held until taken at an edge
  task automatic send_pkt(input logic [0:0] sid, input logic [7:0] p [188]);
    int   n;
    logic ok;  // Ready as it stands at the coming edge
    for (int i = 0; i < 188; i++) begin
      in_beat.sop  = (i == 0);
      in_beat.sid  = sid;
      in_beat.data = p[i];
      in_valid     = 1'b1;
      n = 0;
      // Ready is read between edges, where it is settled
      do begin
        ok = in_ready;
        @(posedge clk_sys);
        #1;
        n++;
      end while (!ok && n < 64);
      if (!ok) hangs++;
    end
    in_valid     = 1'b0;
    in_beat.data = ~in_beat.data;  // Released lines do not keep old data
  endtask : send_pkt

  // Even/odd pair delivered together; bench spaces writes apart
  task automatic load_keys(input logic [0:0] sid, input logic [63:0] ke,
                           input logic [63:0] ko);
    key_sid  = sid;
    key_even = ke;
    key_odd  = ko;
    key_wr   = 1'b1;
    @(posedge clk_sys);
    #1;
    key_wr   = 1'b0;
    key_even = ~ke;  // Stale keys must not be reused
    key_odd  = ~ko;
  endtask : load_keys
endmodule : ts_source_model

// ==== design/beat_fifo.sv ====
// Generic valid/ready FIFO, width and depth set by parameters.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ns
module beat_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [AW-1:0]    wr_ptr;        // Next write slot
  logic [AW-1:0]    rd_ptr;        // Next read slot
  logic [AW:0]      fill;          // Words held
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Full and empty straight from the fill count
  // Compare at full fill width; a narrower depth constant wraps to zero
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  // Storage write, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) fill <= fill + 1'b1;
      else if (pop && !push) fill <= fill - 1'b1;
    end
  end

endmodule : beat_fifo

// ==== design/ts_descrambler.sv ====
// Transport stream packet descrambler with per-stream even/odd key banks.
// Assumes byte-wide packets from a demultiplexer on the same clock and
// key pairs from ECM logic; the block cipher core is a keyed stand-in.
`timescale 1ns/1ns
module ts_descrambler (
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire logic [255:0]         sys_key,
  input  wire logic                 key_wr,
  input  wire logic [0:0]           key_sid,
  input  wire logic [63:0]          key_even,
  input  wire logic [63:0]          key_odd,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire ts_descr_pkg::ts_beat_s in_beat,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output ts_descr_pkg::ts_beat_s    out_beat
);

  // Keyed Feistel stand-in; inverse runs reversed keys on swapped halves
  function automatic logic [63:0] cipher_core(input logic [63:0] x,
      input logic [63:0] dk, input logic [255:0] sk, input logic inv);
    logic [31:0] l;
    logic [31:0] r;
    logic [31:0] t;
    logic [31:0] rk;
    int          k;
    l = inv ? x[31:0] : x[63:32];
    r = inv ? x[63:32] : x[31:0];
    for (int i = 0; i < ts_descr_pkg::ROUNDS; i++) begin
      k  = inv ? ts_descr_pkg::ROUNDS - 1 - i : i;
      rk = sk[32*k +: 32] ^ (k[0] ? dk[31:0] : dk[63:32]);
      t  = r + rk;
      t  = t ^ {t[26:0], t[31:27]} ^ {t[15:0], t[31:16]};
      t  = l ^ t;
      l  = r;
      r  = t;
    end
    return inv ? {r, l} : {l, r};
  endfunction : cipher_core

  // Key banks: live pair, pending pair, per stream
  logic [63:0] bank_even [ts_descr_pkg::NSTREAM];
  logic [63:0] bank_odd  [ts_descr_pkg::NSTREAM];
  logic [63:0] pend_even [ts_descr_pkg::NSTREAM];
  logic [63:0] pend_odd  [ts_descr_pkg::NSTREAM];
  logic [ts_descr_pkg::NSTREAM-1:0] bank_ok;   // ECM key seen
  logic [ts_descr_pkg::NSTREAM-1:0] pend_ok;   // Pair waiting

  // Packet context
  ts_descr_pkg::flow_e state;
  logic [7:0]  idx;        // Byte index of next byte
  logic [0:0]  pkt_sid;    // Stream of current packet
  logic        scr;        // Packet is being descrambled
  logic        use_odd;    // Odd key selected
  logic [1:0]  afc;        // Adaptation control
  logic [7:0]  pay_start;  // First payload byte index
  logic [63:0] act_even;   // Key pair frozen for packet
  logic [63:0] act_odd;
  logic [63:0] chain;      // Previous cipher block
  logic [55:0] blk;        // Partial block bytes
  logic [2:0]  blk_cnt;    // Bytes in partial block
  // Emit buffer
  logic [63:0] ob;
  logic [3:0]  ob_cnt;
  logic        ob_sop;
  logic [0:0]  ob_sid;

  // Handshake with the output buffer
  logic        fifo_in_ready;
  ts_descr_pkg::ts_beat_s fifo_in;

  // Decode of the incoming beat
  wire         take     = in_valid && (state == ts_descr_pkg::S_TAKE);
  wire [7:0]   cur_idx  = in_beat.sop ? 8'h00 : idx;
  wire [7:0]   byte_in  = in_beat.data;
  wire [1:0]   tsc_in   = byte_in[ts_descr_pkg::TSC_MSB -: 2];
  wire [1:0]   afc_in   = byte_in[ts_descr_pkg::AFC_MSB -: 2];
  wire         is_pay   = scr && !in_beat.sop && (cur_idx >= pay_start);
  wire         is_last  = (cur_idx == ts_descr_pkg::PKT_LAST);
  wire         blk_full = (blk_cnt == 3'h7);
  wire [63:0]  blk_in   = {blk, byte_in};
  wire [63:0]  data_key = use_odd ? act_odd : act_even;
  wire [63:0]  keystrm  = cipher_core(chain, data_key, sys_key, 1'b0);
  wire [63:0]  res_al   = blk_in << {(3'h7 - blk_cnt), 3'h0};
  wire [63:0]  dec_blk  = cipher_core(blk_in, data_key, sys_key, 1'b1)
                          ^ chain;
  wire         key_ok_in = bank_ok[pkt_sid];
  wire [7:0]   adapt_end = (byte_in > ts_descr_pkg::ALEN_MAX) ?
                           ts_descr_pkg::PAY_NONE :
                           byte_in + ts_descr_pkg::PAY_ADAPT;

  assign in_ready = (state == ts_descr_pkg::S_TAKE);
  assign fifo_in  = '{sop: ob_sop, sid: ob_sid, data: ob[63:56]};

  // Key banks, one per stream
  for (genvar s = 0; s < ts_descr_pkg::NSTREAM; s++) begin : g_bank
    wire wr_me  = key_wr && (key_sid == 1'(s));
    wire sop_me = take && in_beat.sop && (in_beat.sid == 1'(s));
    // Pending pair is promoted only at a packet start
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        bank_even[s] <= '0;
        bank_odd[s]  <= '0;
        pend_even[s] <= '0;
        pend_odd[s]  <= '0;
        bank_ok[s]   <= 1'b0;
        pend_ok[s]   <= 1'b0;
      end else begin
        if (sop_me && pend_ok[s]) begin
          bank_even[s] <= pend_even[s];
          bank_odd[s]  <= pend_odd[s];
          bank_ok[s]   <= 1'b1;
        end
        // A write in the promote cycle stays pending: set beats clear
        if (wr_me) begin
          pend_even[s] <= key_even;
          pend_odd[s]  <= key_odd;
          pend_ok[s]   <= 1'b1;
        end else if (sop_me) begin
          pend_ok[s]   <= 1'b0;
        end
      end
    end
  end

  // Packet context capture
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      idx       <= '0;
      pkt_sid   <= '0;
      scr       <= 1'b0;
      use_odd   <= 1'b0;
      afc       <= '0;
      pay_start <= ts_descr_pkg::PAY_NONE;
      act_even  <= '0;
      act_odd   <= '0;
    end else if (take) begin
      idx <= cur_idx + 8'h01;
      if (in_beat.sop) begin
        pkt_sid   <= in_beat.sid;
        scr       <= 1'b0;
        pay_start <= ts_descr_pkg::PAY_NONE;
        act_even  <= pend_ok[in_beat.sid] ? pend_even[in_beat.sid]
                                          : bank_even[in_beat.sid];
        act_odd   <= pend_ok[in_beat.sid] ? pend_odd[in_beat.sid]
                                          : bank_odd[in_beat.sid];
      end
      if (cur_idx == ts_descr_pkg::TSC_IDX) begin
        // Clear, reserved, or no key yet: pass through
        scr     <= tsc_in[1] && key_ok_in;
        use_odd <= (tsc_in == ts_descr_pkg::TSC_ODD);
        afc     <= afc_in;
        pay_start <= (afc_in == ts_descr_pkg::AFC_PAY) ?
                     ts_descr_pkg::PAY_PLAIN : ts_descr_pkg::PAY_NONE;
      end
      if (cur_idx == ts_descr_pkg::ALEN_IDX &&
          afc == ts_descr_pkg::AFC_BOTH) begin
        pay_start <= adapt_end;
      end
    end
  end

  // Block gather, decipher and emit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state   <= ts_descr_pkg::S_TAKE;
      chain   <= ts_descr_pkg::CBC_IV;
      blk     <= '0;
      blk_cnt <= '0;
      ob      <= '0;
      ob_cnt  <= '0;
      ob_sop  <= 1'b0;
      ob_sid  <= '0;
    end else begin
      unique case (state)
        ts_descr_pkg::S_TAKE: begin
          if (take && !is_pay) begin
            // Header and clear bytes go out untouched
            ob     <= {byte_in, 56'h0};
            ob_cnt <= 4'h1;
            ob_sop <= in_beat.sop;
            ob_sid <= in_beat.sop ? in_beat.sid : pkt_sid;
            state  <= ts_descr_pkg::S_EMIT;
            if (in_beat.sop) begin
              chain   <= ts_descr_pkg::CBC_IV;
              blk_cnt <= '0;
            end
          end else if (take && blk_full) begin
            ob      <= dec_blk;
            ob_cnt  <= ts_descr_pkg::BLK_BYTES;
            ob_sop  <= 1'b0;
            ob_sid  <= pkt_sid;
            chain   <= blk_in;
            blk_cnt <= '0;
            state   <= ts_descr_pkg::S_EMIT;
          end else if (take && is_last) begin
            // Tail below one block: keystream, not block cipher
            ob      <= res_al ^ keystrm;
            ob_cnt  <= {1'b0, blk_cnt} + 4'h1;
            ob_sop  <= 1'b0;
            ob_sid  <= pkt_sid;
            blk_cnt <= '0;
            state   <= ts_descr_pkg::S_EMIT;
          end else if (take) begin
            blk     <= blk_in[55:0];
            blk_cnt <= blk_cnt + 3'h1;
          end
        end
        ts_descr_pkg::S_EMIT: begin
          // Drains one byte per accepted beat; stalls on a full buffer
          if (fifo_in_ready) begin
            ob     <= {ob[55:0], 8'h00};
            ob_cnt <= ob_cnt - 4'h1;
            ob_sop <= 1'b0;
            if (ob_cnt == 4'h1) state <= ts_descr_pkg::S_TAKE;
          end
        end
      endcase
    end
  end

  // Output buffer between emit stage and the consumer
  beat_fifo #(
    .WIDTH ($bits(ts_descr_pkg::ts_beat_s)),
    .DEPTH (ts_descr_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (state == ts_descr_pkg::S_EMIT),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_beat)
  );

  // Checks on packet handling, all on the one system clock
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  a_hdr_plain: assert property (
    take && !is_pay |=> ob_cnt == 4'h1 && ob[63:56] == $past(byte_in))
    else $error("header byte altered");
  a_clear_pass: assert property (
    take && cur_idx == ts_descr_pkg::TSC_IDX && !tsc_in[1] |=> !scr)
    else $error("clear packet marked scrambled");
  a_nokey_pass: assert property (
    take && cur_idx == ts_descr_pkg::TSC_IDX && !key_ok_in |=> !scr)
    else $error("scrambled without ECM key");
  a_sel_odd: assert property (
    take && cur_idx == ts_descr_pkg::TSC_IDX |=>
    use_odd == ($past(tsc_in) == ts_descr_pkg::TSC_ODD))
    else $error("key parity select wrong");
  a_key_frozen: assert property (
    !(take && in_beat.sop) |=> $stable(act_even) && $stable(act_odd))
    else $error("key changed inside packet");
  a_chain_restart: assert property (
    take && in_beat.sop |=> blk_cnt == 3'h0 && chain == ts_descr_pkg::CBC_IV)
    else $error("block chain not restarted");
  a_blk_emit: assert property (
    take && is_pay && blk_full |=>
    ob_cnt == 4'h8 && state == ts_descr_pkg::S_EMIT)
    else $error("full block not emitted");
  a_tail_len: assert property (
    take && is_pay && is_last && !blk_full |=>
    ob_cnt == {1'b0, $past(blk_cnt)} + 4'h1)
    else $error("tail length wrong");
  a_key_pend: assert property (
    key_wr |=> pend_ok[$past(key_sid)])
    else $error("key pair not held");
  c_odd_pkt: cover property (take && is_pay && use_odd && blk_full);
  c_tail: cover property (take && is_pay && is_last && !blk_full);
  c_stream1: cover property (take && in_beat.sop && in_beat.sid == 1'b1);
  c_stall: cover property (state == ts_descr_pkg::S_EMIT && !fifo_in_ready);

endmodule : ts_descrambler

// ==== pkg/ts_descr_pkg.sv ====
// Shared constants and carrier types for the transport stream descrambler.
// Assumes 188-byte packets delivered one byte per beat, sop on byte 0.
package ts_descr_pkg;

  // Stream count for concurrent tuners
  localparam int         NSTREAM    = 2;
  // Packet geometry, byte indices within a packet
  localparam logic [7:0] PKT_LAST   = 8'hBB;   // Byte 187
  localparam logic [7:0] TSC_IDX    = 8'h03;   // Scramble control byte
  localparam logic [7:0] ALEN_IDX   = 8'h04;   // Adaptation length byte
  localparam logic [7:0] PAY_PLAIN  = 8'h04;   // Payload start, no adaptation
  localparam logic [7:0] PAY_ADAPT  = 8'h05;   // Added to adaptation length
  localparam logic [7:0] PAY_NONE   = 8'hBC;   // No payload in packet
  localparam logic [7:0] ALEN_MAX   = 8'hB7;   // Largest sane adaptation
  // Field positions inside the scramble control byte
  localparam int         TSC_MSB    = 7;
  localparam int         AFC_MSB    = 5;
  // Scramble and adaptation control codes
  localparam logic [1:0] TSC_EVEN   = 2'h2;
  localparam logic [1:0] TSC_ODD    = 2'h3;
  localparam logic [1:0] AFC_PAY    = 2'h1;
  localparam logic [1:0] AFC_BOTH   = 2'h3;
  // Cipher shape
  localparam int         ROUNDS     = 8;
  localparam logic [63:0] CBC_IV    = 64'h0;   // Plain default chain seed
  localparam logic [3:0] BLK_BYTES  = 4'h8;
  // Output buffer depth in bytes
  localparam int         FIFO_DEPTH = 16;

  // One byte of stream with its framing
  typedef struct packed {
    logic       sop;
    logic [0:0] sid;
    logic [7:0] data;
  } ts_beat_s;

  // Input take / byte emit flow
  typedef enum logic [0:0] {
    S_TAKE = 1'b0,
    S_EMIT = 1'b1
  } flow_e;

endpackage : ts_descr_pkg
